// ---- core/mbh_arbiter.sv ----
// mbh_arbiter: request/grant handover, bus-lock output and queue-status outputs
// assumes the bus interface unit reports its T-state and cycle attributes on ref_clk
// Operation
// - in last or idle clock, float bus, send one-clock low grant, then hold
// - during grant sequence the bus unit is disconnected and starts no cycles
// - on reclaim enter last state, or first state when nothing is pending
// - every handover is exactly request, grant, release pulses
// - at least one idle clock follows every exchange before the next
// - request, grant and release pulses are active low
// - lines are bidirectional; high-priority line wins over low-priority line
// - each line has a pull-up hold so an open line reads high
// - memory-cycle request releases in last state only if arrived by second state
// - no release after low byte of an odd-address word
// - no release after first interrupt acknowledge cycle
// - grant withheld while a locked instruction executes
// - idle-bus request may be released during the next cycle
// - or a cycle starts within three clocks and active-cycle conditions apply
// - low bus-lock tells other masters not to take the system bus
// - bus-lock asserted by lock prefix, held until following instruction completes
// - bus-lock active low, driven high when idle except during grant sequence
// - bus-lock auto-asserted in second state of first ack, removed in second ack
// - queue status shows an operation in the clock after it happened
// - queue status is always driven, even during grant sequence
// - codes: 00 none, 01 first opcode byte, 10 queue emptied
`timescale 1ns/1ps
module mbh_arbiter
    import mbh_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // request/grant pins, input/output/enable each
    input wire logic hold_req_grant_hi_pri_i,
    output logic hold_req_grant_hi_pri_o,
    output logic hold_req_grant_hi_pri_oe,
    input wire logic hold_req_grant_lo_pri_i,
    output logic hold_req_grant_lo_pri_o,
    output logic hold_req_grant_lo_pri_oe,
    // bus interface unit status
    input wire logic bus_idle_state,
    input wire logic bus_state_first,
    input wire logic bus_state_second,
    input wire logic bus_state_last,
    input wire logic cycle_pending,
    input wire logic odd_low_byte,
    input wire logic interrupt_ack_cycle,
    input wire logic first_ack,
    input wire logic lock_prefix,
    input wire logic instr_done,
    // queue operation of this clock
    input wire logic queue_op_valid,
    input wire logic [1:0] queue_op_code,
    // control towards the bus interface unit
    output logic bus_float,
    output logic bus_reclaim,
    output logic resume_last,
    // bus-lock and queue status pins
    output logic bus_lock_n,
    output logic bus_lock_oe,
    output logic queue_state_msb,
    output logic queue_state_lsb
);
    mbh_state_e st_q, st_d;
    logic hi_s1_q, hi_s2_q, lo_s1_q, lo_s2_q;
    logic sel_lo_q, sel_lo_d;
    logic late_q, late_d;
    logic [1:0] idle_cnt_q, idle_cnt_d;
    logic grant_q, grant_d;
    logic float_q, float_d;
    logic recl_q, recl_d;
    logic last_q, last_d;
    logic lock_pref_q, lock_pref_d;
    logic lock_wait_q, lock_wait_d;
    logic ack_lock_q, ack_lock_d;
    logic [1:0] qs_q, qs_d;
    logic echo1_q, echo2_q;
    logic oe_hi_q, oe_hi_d, oe_lo_q, oe_lo_d;
    logic lock_n_q, lock_n_d, lock_oe_q, lock_oe_d;
    logic req_hi, req_lo, req_any, line_low, rel_seen, may_release;

    // pins first pass two flops; open pins read high from the pull-up
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_s1_q <= 1'b1;
            hi_s2_q <= 1'b1;
            lo_s1_q <= 1'b1;
            lo_s2_q <= 1'b1;
            echo1_q <= 1'b0;
            echo2_q <= 1'b0;
        end else begin
            hi_s1_q <= hold_req_grant_hi_pri_i;
            hi_s2_q <= hi_s1_q;
            lo_s1_q <= hold_req_grant_lo_pri_i;
            lo_s2_q <= lo_s1_q;
            echo1_q <= grant_q;
            echo2_q <= echo1_q;
        end
    end

    assign req_hi = !hi_s2_q;
    assign req_lo = !lo_s2_q;
    assign req_any = req_hi || req_lo;
    assign line_low = sel_lo_q ? req_lo : req_hi;
    // our own grant returns through the synchroniser two clocks later; it is no release
    assign rel_seen = line_low && !echo2_q;

    // a locked instruction or the odd low byte or first ack blocks release
    assign may_release = (bus_idle_state || bus_state_last) && !lock_pref_q && !lock_wait_q
        && !(bus_state_last && (odd_low_byte || (interrupt_ack_cycle && first_ack))
        && !bus_idle_state) && !late_q;

    always_comb begin
        st_d = st_q;
        sel_lo_d = sel_lo_q;
        late_d = late_q;
        idle_cnt_d = idle_cnt_q;
        grant_d = 1'b0;
        float_d = float_q;
        recl_d = 1'b0;
        last_d = last_q;
        oe_hi_d = 1'b0;
        oe_lo_d = 1'b0;
        unique case (st_q)
            MBH_ST_IDLE: begin
                if (req_any) begin
                    sel_lo_d = !req_hi;
                    // request seen after second state misses this cycle's last state
                    late_d = !bus_idle_state && !bus_state_first && !bus_state_second;
                    idle_cnt_d = 2'(MBH_IDLE_START_CLK - 1);
                    st_d = MBH_ST_WAIT;
                end
            end
            MBH_ST_WAIT: begin
                if (may_release) begin
                    grant_d = 1'b1;
                    float_d = 1'b1;
                    oe_hi_d = !sel_lo_q;
                    oe_lo_d = sel_lo_q;
                    st_d = MBH_ST_GRANT;
                end else if (bus_state_first) begin
                    late_d = 1'b0;
                end else if (bus_state_last && late_q) begin
                    late_d = 1'b0;
                end
                if (bus_idle_state && idle_cnt_q != 2'h0) begin
                    idle_cnt_d = idle_cnt_q - 2'h1;
                end
            end
            MBH_ST_GRANT: begin
                st_d = MBH_ST_HOLD;
            end
            MBH_ST_HOLD: begin
                if (rel_seen) begin
                    st_d = MBH_ST_REL;
                end
            end
            MBH_ST_REL: begin
                float_d = 1'b0;
                recl_d = 1'b1;
                last_d = cycle_pending;
                st_d = MBH_ST_GAP;
            end
            MBH_ST_GAP: begin
                st_d = MBH_ST_IDLE;
            end
            default: begin
                st_d = MBH_ST_IDLE;
                float_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= MBH_ST_IDLE;
            sel_lo_q <= 1'b0;
            late_q <= 1'b0;
            idle_cnt_q <= 2'h0;
            grant_q <= 1'b0;
            float_q <= 1'b0;
            recl_q <= 1'b0;
            last_q <= 1'b0;
            oe_hi_q <= 1'b0;
            oe_lo_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sel_lo_q <= sel_lo_d;
            late_q <= late_d;
            idle_cnt_q <= idle_cnt_d;
            grant_q <= grant_d;
            float_q <= float_d;
            recl_q <= recl_d;
            last_q <= last_d;
            oe_hi_q <= oe_hi_d;
            oe_lo_q <= oe_lo_d;
        end
    end

    // grant pulse driven only on the selected line, low for one clock
    assign hold_req_grant_hi_pri_o = 1'b0;
    assign hold_req_grant_lo_pri_o = 1'b0;
    assign hold_req_grant_hi_pri_oe = oe_hi_q;
    assign hold_req_grant_lo_pri_oe = oe_lo_q;
    assign bus_float = float_q;
    assign bus_reclaim = recl_q;
    assign resume_last = last_q;

    // lock: prefix holds until next instruction done; ack sequence sets its own hold
    always_comb begin
        lock_pref_d = lock_pref_q;
        lock_wait_d = lock_wait_q;
        ack_lock_d = ack_lock_q;
        if (lock_prefix) begin
            lock_pref_d = 1'b1;
        end else if (lock_pref_q && instr_done) begin
            lock_pref_d = 1'b0;
            lock_wait_d = 1'b1;
        end else if (lock_wait_q && instr_done) begin
            lock_wait_d = 1'b0;
        end
        if (interrupt_ack_cycle && bus_state_second) begin
            ack_lock_d = first_ack;
        end
        qs_d = queue_op_valid ? queue_op_code : MBH_QS_NOP;
        lock_n_d = !(lock_pref_d || lock_wait_d || ack_lock_d);
        lock_oe_d = !float_d;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_pref_q <= 1'b0;
            lock_wait_q <= 1'b0;
            ack_lock_q <= 1'b0;
            qs_q <= MBH_QS_RST;
            lock_n_q <= 1'b1;
            lock_oe_q <= 1'b1;
        end else begin
            lock_pref_q <= lock_pref_d;
            lock_wait_q <= lock_wait_d;
            ack_lock_q <= ack_lock_d;
            qs_q <= qs_d;
            lock_n_q <= lock_n_d;
            lock_oe_q <= lock_oe_d;
        end
    end

    // both lock pins come straight from their own flops
    assign bus_lock_n = lock_n_q;
    assign bus_lock_oe = lock_oe_q;
    assign queue_state_msb = qs_q[1];
    assign queue_state_lsb = qs_q[0];

    property p_grant_one_clk;
        @(posedge ref_clk) disable iff (!arst_n)
        $rose(grant_q) |=> !grant_q;
    endproperty
    a_grant_one_clk: assert property (p_grant_one_clk) else $error("grant wider than one clock");

    property p_float_in_hold;
        @(posedge ref_clk) disable iff (!arst_n)
        (st_q == MBH_ST_HOLD) |-> bus_float && !bus_lock_oe;
    endproperty
    a_float_in_hold: assert property (p_float_in_hold) else $error("bus driven in hold");

    property p_gap_idle;
        @(posedge ref_clk) disable iff (!arst_n)
        $rose(recl_q) |=> !grant_q ##1 !grant_q;
    endproperty
    a_gap_idle: assert property (p_gap_idle) else $error("no idle clock after exchange");

    property p_no_grant_locked;
        @(posedge ref_clk) disable iff (!arst_n)
        (lock_pref_q || lock_wait_q) |=> !grant_q;
    endproperty
    a_no_grant_locked: assert property (p_no_grant_locked) else $error("grant while locked");

    property p_qs_follow;
        @(posedge ref_clk) disable iff (!arst_n)
        queue_op_valid |=> {queue_state_msb, queue_state_lsb} == $past(queue_op_code);
    endproperty
    a_qs_follow: assert property (p_qs_follow) else $error("queue status not next clock");

    property p_lock_prefix;
        @(posedge ref_clk) disable iff (!arst_n)
        lock_prefix |=> !bus_lock_n;
    endproperty
    a_lock_prefix: assert property (p_lock_prefix) else $error("lock not asserted");

    property p_one_line;
        @(posedge ref_clk) disable iff (!arst_n)
        !(hold_req_grant_hi_pri_oe && hold_req_grant_lo_pri_oe);
    endproperty
    a_one_line: assert property (p_one_line) else $error("both lines granted");

    property p_reclaim_after_rel;
        @(posedge ref_clk) disable iff (!arst_n)
        (st_q == MBH_ST_HOLD && rel_seen) |=> ##1 recl_q;
    endproperty
    a_reclaim_after_rel: assert property (p_reclaim_after_rel) else $error("no reclaim");

    property p_echo_ignored;
        @(posedge ref_clk) disable iff (!arst_n)
        (st_q == MBH_ST_HOLD && echo2_q) |=> (st_q == MBH_ST_HOLD);
    endproperty
    a_echo_ignored: assert property (p_echo_ignored) else $error("own grant taken as release");

endmodule // mbh_arbiter

// ---- common/mbh_pkg.sv ----
// mbh_pkg: constants and types for the maximum-mode bus handover block
// assumes one clock domain (ref_clk) and an asynchronous active-low reset
package mbh_pkg;
    // queue status codes
    localparam logic [1:0] MBH_QS_NOP = 2'h0;
    localparam logic [1:0] MBH_QS_FIRST = 2'h1;
    localparam logic [1:0] MBH_QS_EMPTY = 2'h2;
    localparam logic [1:0] MBH_QS_SUBSEQ = 2'h3;
    localparam logic [1:0] MBH_QS_RST = 2'h0;
    // pulse width of request, grant and release, in clocks
    localparam int MBH_PULSE_CLK = 1;
    // an idle-bus request may be overtaken by a cycle starting within this many clocks
    localparam int MBH_IDLE_START_CLK = 3;
    // arbiter states, gray along idle -> wait -> grant -> hold -> release
    typedef enum logic [2:0] {
        MBH_ST_IDLE = 3'h0,
        MBH_ST_WAIT = 3'h1,
        MBH_ST_GRANT = 3'h3,
        MBH_ST_HOLD = 3'h2,
        MBH_ST_REL = 3'h6,
        MBH_ST_GAP = 3'h7
    } mbh_state_e;
endpackage

// ---- tb/mbh_master_model.sv ----
// mbh_master_model: second local bus master on one request/grant line
// assumes line is the resolved pin level with its pull-up applied
`timescale 1ns/1ps
module mbh_master_model #(
    parameter int HOLD_CLK = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // command from the bench
    input wire logic start,
    // request/grant line
    input wire logic line,
    output logic pull_low
);
    logic [2:0] st_q;
    logic [7:0] cnt_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= 3'h0;
            cnt_q <= 8'h00;
            pull_low <= 1'b0;
        end else begin
            pull_low <= 1'b0;
            case (st_q)
                3'h0: if (start) begin
                    pull_low <= 1'b1;
                    st_q <= 3'h1;
                end
                3'h1: st_q <= 3'h2;
                // only the grant can pull the line now, our own pulse is over
                3'h2: if (!line) begin
                    cnt_q <= 8'h00;
                    st_q <= 3'h3;
                end
                3'h3: if (cnt_q == 8'(HOLD_CLK)) begin
                    pull_low <= 1'b1;
                    st_q <= 3'h0;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
                default: st_q <= 3'h0;
            endcase
        end
    end
endmodule // mbh_master_model

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for the bus handover arbiter
// assumes one master model per request/grant line, pull-ups resolved here
`timescale 1ns/1ps
module tb_top;
    import mbh_pkg::*;
    logic ref_clk, arst_n, idle, second, cp, ack, fa, lk, idone, qv, go_hi, go_lo;
    logic st_first, st_last, odd;
    logic [1:0] qc;
    logic hi_o, hi_oe, lo_o, lo_oe, pl_hi, pl_lo, line_hi, line_lo, bus_float, bus_reclaim;
    logic resume_last, bus_lock_n, bus_lock_oe, qs_m, qs_l;
    int err_count, total_checks, cyc;
    // open-drain lines with pull-up: low when any party pulls
    assign line_hi = !((hi_oe && !hi_o) || pl_hi);
    assign line_lo = !((lo_oe && !lo_o) || pl_lo);
    mbh_arbiter mbh_arbiter_i (.ref_clk(ref_clk), .arst_n(arst_n),
        .hold_req_grant_hi_pri_i(line_hi), .hold_req_grant_hi_pri_o(hi_o),
        .hold_req_grant_hi_pri_oe(hi_oe), .hold_req_grant_lo_pri_i(line_lo),
        .hold_req_grant_lo_pri_o(lo_o), .hold_req_grant_lo_pri_oe(lo_oe),
        .bus_idle_state(idle), .bus_state_first(st_first), .bus_state_second(second),
        .bus_state_last(st_last), .cycle_pending(cp), .odd_low_byte(odd),
        .interrupt_ack_cycle(ack), .first_ack(fa), .lock_prefix(lk), .instr_done(idone),
        .queue_op_valid(qv), .queue_op_code(qc), .bus_float(bus_float),
        .bus_reclaim(bus_reclaim), .resume_last(resume_last), .bus_lock_n(bus_lock_n),
        .bus_lock_oe(bus_lock_oe), .queue_state_msb(qs_m), .queue_state_lsb(qs_l));
    mbh_master_model m_hi_i (.ref_clk(ref_clk), .arst_n(arst_n), .start(go_hi),
        .line(line_hi), .pull_low(pl_hi));
    mbh_master_model m_lo_i (.ref_clk(ref_clk), .arst_n(arst_n), .start(go_lo),
        .line(line_lo), .pull_low(pl_lo));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = !ref_clk;
    end
    task print_verdict;
        if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // a hang costs a mismatch, the whole run needs well under a thousand clocks
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            print_verdict;
        end
    end
    task check(input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task do_reset;
        arst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(negedge ref_clk);
        check({bus_lock_n, bus_lock_oe, bus_float, hi_oe}, 4'hC);
    endtask
    task wait_grant(output logic [1:0] g);
        g = 2'h0;
        for (int i = 0; i < 20 && g == 2'h0; i++) begin
            @(negedge ref_clk);
            g = {hi_oe, lo_oe};
        end
    endtask
    task wait_reclaim;
        for (int i = 0; i < 30 && bus_reclaim !== 1'b1; i++) @(negedge ref_clk);
        check(bus_reclaim, 1'b1);
        check(bus_float, 1'b0);
    endtask
    task start_req(input logic h, input logic l);
        @(posedge ref_clk);
        go_hi <= h;
        go_lo <= l;
        @(posedge ref_clk);
        go_hi <= 1'b0;
        go_lo <= 1'b0;
    endtask
    task t_queue;
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            qv <= 1'b1;
            qc <= 2'(i);
            @(posedge ref_clk);
            qv <= 1'b0;
            @(negedge ref_clk);
            check({qs_m, qs_l}, 4'(i));
        end
    endtask
    task t_handover(input logic pend);
        logic [1:0] g;
        cp <= pend;
        start_req(1'b1, 1'b0);
        wait_grant(g);
        check(g, 2'h2);
        check(bus_float, 1'b1);
        @(negedge ref_clk);
        check({bus_lock_oe, hi_oe, qs_m, qs_l}, 4'h0);
        wait_reclaim;
        check(resume_last, pend);
    endtask
    task t_lock;
        logic [1:0] g;
        @(posedge ref_clk);
        lk <= 1'b1;
        @(posedge ref_clk);
        lk <= 1'b0;
        @(negedge ref_clk);
        check(bus_lock_n, 1'b0);
        start_req(1'b1, 1'b0);
        wait_grant(g);
        check(g, 2'h0);
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            idone <= 1'b1;
            @(posedge ref_clk);
            idone <= 1'b0;
        end
        @(negedge ref_clk);
        check(bus_lock_n, 1'b1);
        wait_grant(g);
        check(g, 2'h2);
        wait_reclaim;
    endtask
    task t_ack;
        @(posedge ref_clk);
        {idle, second, ack, fa} <= 4'h7;
        @(posedge ref_clk);
        second <= 1'b0;
        @(negedge ref_clk);
        check(bus_lock_n, 1'b0);
        @(posedge ref_clk);
        {second, fa} <= 2'h2;
        @(posedge ref_clk);
        {idle, second, ack} <= 3'h4;
        @(negedge ref_clk);
        check(bus_lock_n, 1'b1);
    endtask
    task bus_step(input logic [4:0] st, input logic exp_oe);
        @(posedge ref_clk);
        {st_first, st_last, odd, ack, fa} <= st;
        @(negedge ref_clk);
        check(hi_oe, exp_oe);
    endtask
    // request seen between second and last state, so that cycle's last state is too late
    task t_cycle;
        @(posedge ref_clk);
        idle <= 1'b0;
        start_req(1'b1, 1'b0);
        bus_step(5'h00, 1'b0);
        bus_step(5'h00, 1'b0);
        bus_step(5'h08, 1'b0);
        bus_step(5'h10, 1'b0);
        bus_step(5'h0C, 1'b0);
        bus_step(5'h10, 1'b0);
        bus_step(5'h0B, 1'b0);
        bus_step(5'h10, 1'b0);
        bus_step(5'h08, 1'b0);
        bus_step(5'h00, 1'b1);
        @(posedge ref_clk);
        idle <= 1'b1;
        wait_reclaim;
        check(resume_last, cp);
    endtask
    task t_prio;
        logic [1:0] g;
        start_req(1'b1, 1'b1);
        wait_grant(g);
        check(g, 2'h2);
        wait_reclaim;
        // the losing master waits for a grant that never comes, reset frees it
        @(posedge ref_clk);
        do_reset;
    endtask
    initial begin
        {arst_n, second, cp, ack, fa, lk, idone, qv, go_hi, go_lo} = 10'h000;
        {st_first, st_last, odd} = 3'h0;
        idle = 1'b1;
        qc = 2'h0;
        err_count = 0;
        total_checks = 0;
        cyc = 0;
        do_reset;
        t_queue;
        t_handover(1'b0);
        repeat (4) @(posedge ref_clk);
        t_handover(1'b1);
        repeat (4) @(posedge ref_clk);
        t_lock;
        repeat (4) @(posedge ref_clk);
        t_ack;
        t_cycle;
        t_prio;
        print_verdict;
    end
endmodule // tb_top
